// ### verif/i2c_host_model.sv
// host i2c master model with open-drain bus resolution
`timescale 1ns/1ps
module i2c_host_model #(
  parameter int GUARD_NS = 250000
) (
  input wire logic scl_oe,
  input wire logic scl_out,
  input wire logic sda_oe,
  input wire logic sda_out,
  output logic scl,
  output logic sda
);
  logic scl_low = 1'b0;
  logic sda_low = 1'b0;
  // ================================================================
  // wired-and, external pull-ups take released lines high
  assign scl = !(scl_low || (scl_oe && !scl_out));
  assign sda = !(sda_low || (sda_oe && !sda_out));
  // ================================================================
  // bus phases, 48 ns bit time
  task automatic rise();
    scl_low = 1'b0;
    for (int i = 0; i < 4000 && scl !== 1'b1; i++) #1;
  endtask : rise
  // gap kept between frames while the real value is still unknown
  task automatic guard();
    #GUARD_NS;
  endtask : guard
  // also serves as repeated start from a low clock
  task automatic start();
    sda_low = 1'b0;
    #12;
    rise();
    #12;
    sda_low = 1'b1;
    #12;
    scl_low = 1'b1;
    #12;
  endtask : start
  task automatic stop();
    sda_low = 1'b1;
    #12;
    rise();
    #12;
    sda_low = 1'b0;
    #24;
    guard();
  endtask : stop
  // sample late in the high phase: ack may come late after the fall
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--)
    begin
      sda_low = !tx[i];
      #12;
      rise();
      #24;
      rx[i] = sda;
      scl_low = 1'b1;
      #12;
    end
  endtask : xfer
endmodule : i2c_host_model

// ### verif/security_module_i2c_target_init_assertions.sv
// concurrent checks on readiness, interrupt and pin drive
`timescale 1ns/1ps
module security_module_i2c_target_init_assertions
  import i2c_target_pkg::*;
#(
  parameter int TIMEOUT_D_CYC = 400,
  parameter int FIPS2_CYC = 200,
  parameter int FIPS3_CYC = 300,
  parameter int NV_CYC = 600
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic init_indication,
  input wire logic self_test_done,
  input wire logic [1:0] selftest_mode,
  input wire logic nv_recovery,
  input wire logic irq_enable,
  input wire logic response_avail,
  input wire logic host_irq_n,
  input wire logic reg_valid_flag,
  input wire logic valid_level,
  input wire logic cmd_ready
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  int wait_reg;
  int lim;
  // ================================================================
  // cycles spent waiting for readiness since the last init
  always_comb lim = nv_recovery ? NV_CYC : selftest_mode == MODE_FIPS2 ? FIPS2_CYC :
    selftest_mode == MODE_FIPS3 ? FIPS3_CYC : TIMEOUT_D_CYC;
  always_ff @(posedge clock)
  begin
    if (srst || init_indication)
      wait_reg <= 0;
    else if (!reg_valid_flag)
      wait_reg <= wait_reg + 1;
  end
  // ================================================================
  // checks
  level_valid_a: assert property (init_indication |-> ##2 valid_level)
    else $error("valid level late after init");
  flag_needs_level_a: assert property (!valid_level |-> !reg_valid_flag)
    else $error("valid flag without valid level");
  ready_stands_a: assert property (reg_valid_flag && !init_indication |=> reg_valid_flag)
    else $error("valid flag dropped");
  deadline_met_a: assert property (valid_level && !reg_valid_flag |-> wait_reg <= lim + 2)
    else $error("readiness deadline missed");
  ready_pair_a: assert property (cmd_ready == reg_valid_flag)
    else $error("command ready differs from valid flag");
  selftest_ready_a: assert property (valid_level && self_test_done && !init_indication
    |=> reg_valid_flag)
    else $error("self test end not taken");
  irq_low_a: assert property ((irq_enable && response_avail) [*2] |-> !host_irq_n)
    else $error("host interrupt not asserted");
  pins_low_only_a: assert property ((scl_oe |-> !scl_out) and (sda_oe |-> !sda_out))
    else $error("pin driven high");
  reset_state_a: assert property ($fell(srst) |-> !reg_valid_flag && host_irq_n && !scl_oe
    && !sda_oe)
    else $error("outputs wrong after reset");
endmodule : security_module_i2c_target_init_assertions

bind security_module_i2c_target_init security_module_i2c_target_init_assertions #(
  .TIMEOUT_D_CYC(TIMEOUT_D_CYC),
  .FIPS2_CYC(FIPS2_CYC),
  .FIPS3_CYC(FIPS3_CYC),
  .NV_CYC(NV_CYC)
) u_chk (.*);

// ### verif/tb_security_module_i2c_target_init.sv
// self-checking bench for the i2c target with readiness logic
`timescale 1ns/1ps
module tb_security_module_i2c_target_init;
  import i2c_target_pkg::*;
  logic clock, srst, scl, sda, init_indication, self_test_done, nv_recovery, crb_mode;
  logic core_busy, response_avail, irq_enable, scl_out, scl_oe, sda_out, sda_oe;
  logic host_irq_n, reg_valid_flag, valid_level, cmd_ready, deadline_forced;
  logic [1:0] selftest_mode;
  logic [7:0] a, b;
  logic [8:0] rx;
  int err_count, num_checks, cyc, n;
  int lim [4] = '{400, 200, 300, 600};
  time t0;
  security_module_i2c_target_init #(.VALID_LEVEL_CYC(50), .TIMEOUT_D_CYC(400),
    .FIPS2_CYC(200), .FIPS3_CYC(300), .NV_CYC(600)) u_dut (.clock(clock), .srst(srst),
    .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .init_indication(init_indication), .self_test_done(self_test_done),
    .selftest_mode(selftest_mode), .nv_recovery(nv_recovery), .crb_mode(crb_mode),
    .core_busy(core_busy), .response_avail(response_avail), .irq_enable(irq_enable),
    .host_irq_n(host_irq_n), .reg_valid_flag(reg_valid_flag), .valid_level(valid_level),
    .cmd_ready(cmd_ready), .deadline_forced(deadline_forced));
  // guard time shortened like the deadlines, to keep the run short
  i2c_host_model #(.GUARD_NS(100)) u_host (.scl_oe(scl_oe), .scl_out(scl_out), .sda_oe(sda_oe),
    .sda_out(sda_out), .scl(scl), .sda(sda));
  // ================================================================
  // checking and ending
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %0t seen %0h want %0h", $time, seen, exp);
    end
  endtask : chk
  task automatic results();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : results
  // ================================================================
  // access tasks, ack is sda low on the ninth clock
  task automatic wr_reg(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d);
    u_host.start();
    u_host.xfer({dev, 2'b01}, rx);
    chk(rx[0], 0);
    u_host.xfer({ptr, 1'b1}, rx);
    chk(rx[0], 0);
    u_host.xfer({d, 1'b1}, rx);
    chk(rx[0], 0);
    u_host.stop();
  endtask : wr_reg
  task automatic rd_reg(input logic [6:0] dev, input logic [7:0] ptr);
    u_host.start();
    u_host.xfer({dev, 2'b01}, rx);
    u_host.xfer({ptr, 1'b1}, rx);
    u_host.guard();
    u_host.start();
    u_host.xfer({dev, 2'b11}, rx);
    chk(rx[0], 0);
    u_host.xfer({8'hFF, 1'b0}, rx);
    a = rx[8:1];
    u_host.xfer({8'hFF, 1'b1}, rx);
    b = rx[8:1];
    u_host.stop();
  endtask : rd_reg
  task automatic pulse();
    @(posedge clock);
    init_indication <= 1'b1;
    @(posedge clock);
    init_indication <= 1'b0;
  endtask : pulse
  // ================================================================
  // clock and hang guard
  always #2.5 clock = ~clock;
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      results();
    end
  end
  // ================================================================
  // main sequence
  initial
  begin
    {clock, init_indication, self_test_done, nv_recovery, crb_mode} = 5'h00;
    {core_busy, response_avail, irq_enable, selftest_mode} = 5'h00;
    srst = 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    repeat (3) @(posedge clock);
    for (int m = 0; m < 4; m++)
    begin
      selftest_mode <= m[1:0];
      nv_recovery <= m == 3;
      crb_mode <= m[0];
      pulse();
      repeat (2) @(posedge clock);
      #1 chk(valid_level, 1);
      for (n = 0; !reg_valid_flag && n < 2000; n++) @(posedge clock);
      chk(n <= lim[m] && n + 4 >= lim[m], 1);
      chk(deadline_forced, 1);
      chk(cmd_ready, 1);
    end
    // access register read while still waiting: flag low, fields defined
    pulse();
    rd_reg(7'h2E, 8'h00);
    chk(a, 8'h01);
    chk(b, 8'h00);
    @(posedge clock);
    self_test_done <= 1'b1;
    repeat (3) @(posedge clock);
    #1 chk({reg_valid_flag, deadline_forced}, 2'b10);
    @(posedge clock);
    response_avail <= 1'b1;
    irq_enable <= 1'b1;
    repeat (3) @(posedge clock);
    #1 chk(host_irq_n, 0);
    rd_reg(7'h2E, 8'h00);
    chk({a, b}, 16'h8103);
    @(posedge clock);
    irq_enable <= 1'b0;
    repeat (3) @(posedge clock);
    #1 chk(host_irq_n, 1);
    rd_reg(7'h2E, 8'h02);
    chk(a, 8'h01);
    // slow core holds the clock low after the pointer byte
    @(posedge clock);
    core_busy <= 1'b1;
    t0 = $time;
    fork
      wr_reg(7'h2E, 8'h04, 8'hA5);
      begin
        repeat (400) @(posedge clock);
        core_busy <= 1'b0;
      end
    join
    chk($time - t0 > 2000, 1);
    wr_reg(7'h2E, 8'h05, 8'h3C);
    rd_reg(7'h2E, 8'h04);
    chk({a, b}, 16'hA53C);
    wr_reg(7'h2E, 8'h03, 8'h31);
    for (int k = 0; k < 2; k++)
    begin
      u_host.start();
      u_host.xfer({k ? 7'h2F : 7'h2E, 2'b01}, rx);
      chk(rx[0], 1);
      u_host.stop();
    end
    rd_reg(7'h31, 8'h04);
    chk(a, 8'hA5);
    results();
  end
endmodule : tb_security_module_i2c_target_init

// ### verilog/i2c_target_defs.svh
// constants for the security module i2c target and readiness logic
// Function
// - fifo access registers valid level within 500us
// - crb locality state valid level within 500us
// - access register reads never return garbage
// - fifo: valid flag reaches one, command accepted
// - plain device ready within readiness timeout d
// - fips 140-2 device valid within 50ms
// - fips 140-3 device ready within 200ms
// - nv recovery ready within one second
// - crb registers all valid by deadline, ready
// - operate at fast-mode rates up to 400k
// - higher speeds advertised in capability register; the code advertises fast mode only (CAP_SPEED_FM)
// - one 7-bit address, default 0x2E
// - address byte 0x5D read, 0x5C write
// - target address reconfigurable via address register
// - accept repeated start write then read
// - throttle only by holding scl low
// - active-low host interrupt for events
`ifndef I2C_TARGET_DEFS_SVH
`define I2C_TARGET_DEFS_SVH

// ================================================================
// clock and deadlines
`define CLK_MHZ 200
`define VALID_LEVEL_US 500
`define TIMEOUT_D_MS 750
`define FIPS2_MS 50
`define FIPS3_MS 200
`define NV_MS 1000
`define GUARD_US 250
`define VALID_LEVEL_CYC (`VALID_LEVEL_US * `CLK_MHZ)
`define TIMEOUT_D_CYC (`TIMEOUT_D_MS * 1000 * `CLK_MHZ)
`define FIPS2_CYC (`FIPS2_MS * 1000 * `CLK_MHZ)
`define FIPS3_CYC (`FIPS3_MS * 1000 * `CLK_MHZ)
`define NV_CYC (`NV_MS * 1000 * `CLK_MHZ)
`define STRETCH_CYC 2'h2

// ================================================================
// address and register map
`define DEV_ADDR_RST 7'h2E
`define REG_ACCESS 8'h00
`define REG_STATUS 8'h01
`define REG_CAP 8'h02
`define REG_DEV_ADDR 8'h03
`define REG_MEM_BASE 8'h04
`define VALID_BIT 7
`define CAP_SPEED_LSB 0
`define CAP_SPEED_FM 2'h1
`define READ_IDLE 8'hFF

`endif

// ### verilog/i2c_target_pkg.sv
// types for the security module i2c target
package i2c_target_pkg;
  typedef enum {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_WR_BYTE,
    ST_WR_ACK,
    ST_RD_BYTE,
    ST_RD_ACK
  } i2c_state_e;

  typedef enum logic [1:0] {
    MODE_PLAIN,
    MODE_FIPS2,
    MODE_FIPS3
  } selftest_mode_e;
endpackage : i2c_target_pkg

// ### verilog/reg_mem.sv
// small register memory with registered read data
`timescale 1ns/1ps
module reg_mem #(
  parameter int DEPTH = 16,
  parameter int WIDTH = 8,
  parameter int AW = 4
) (
  input wire logic clock,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clock)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clock)
  begin
    rd_data <= mem[rd_addr];
  end
endmodule : reg_mem

// ### verilog/security_module_i2c_target_init.sv
// i2c target front end with post-init register readiness
`timescale 1ns/1ps
`include "i2c_target_defs.svh"
module security_module_i2c_target_init
  import i2c_target_pkg::*;
#(
  parameter int MEM_DEPTH = 16,
  parameter int MEM_AW = 4,
  parameter int VALID_LEVEL_CYC = `VALID_LEVEL_CYC,
  parameter int TIMEOUT_D_CYC = `TIMEOUT_D_CYC,
  parameter int FIPS2_CYC = `FIPS2_CYC,
  parameter int FIPS3_CYC = `FIPS3_CYC,
  parameter int NV_CYC = `NV_CYC,
  parameter logic [1:0] SPEED_CAP = `CAP_SPEED_FM
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic init_indication,
  input wire logic self_test_done,
  input wire logic [1:0] selftest_mode,
  input wire logic nv_recovery,
  input wire logic crb_mode,
  input wire logic core_busy,
  input wire logic response_avail,
  input wire logic irq_enable,
  output logic host_irq_n,
  output logic reg_valid_flag,
  output logic valid_level,
  output logic cmd_ready,
  output logic deadline_forced
);
  // ================================================================
  // pin synchronisers
  logic [1:0] pins_sync;
  logic scl_s;
  logic sda_s;
  logic scl_d_reg;
  logic sda_d_reg;

  sync2 #(.WIDTH(2)) u_sync (
    .clock(clock),
    .srst(srst),
    .async_in({scl_in, sda_in}),
    .sync_out(pins_sync)
  );
  assign scl_s = pins_sync[1];
  assign sda_s = pins_sync[0];

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end
    else
    begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  // sampling at 200 MHz leaves wide margin for 400k fast mode
  assign scl_rise = scl_s & ~scl_d_reg;
  assign scl_fall = ~scl_s & scl_d_reg;
  assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_det = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  // ================================================================
  // readiness after init indication
  localparam int CW = 28;
  logic [CW-1:0] init_cnt_reg;
  logic counting_reg;
  logic [CW-1:0] deadline;

  always_comb
  begin
    if (nv_recovery)
      deadline = CW'(NV_CYC);
    else
    begin
      case (selftest_mode_e'(selftest_mode))
        MODE_FIPS2: deadline = CW'(FIPS2_CYC);
        MODE_FIPS3: deadline = CW'(FIPS3_CYC);
        default: deadline = CW'(TIMEOUT_D_CYC);
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      counting_reg <= 1'b0;
      init_cnt_reg <= '0;
    end
    else if (init_indication)
    begin
      counting_reg <= 1'b1;
      init_cnt_reg <= '0;
    end
    else if (counting_reg && !reg_valid_flag)
      init_cnt_reg <= init_cnt_reg + 1'b1;
  end
  // valid level is reached at once; the window only bounds it
  always_ff @(posedge clock)
  begin
    if (srst || init_indication)
      valid_level <= 1'b0;
    else if (counting_reg && init_cnt_reg < CW'(VALID_LEVEL_CYC))
      valid_level <= 1'b1;
  end
  // deadline forces readiness so the host never waits past it
  always_ff @(posedge clock)
  begin
    if (srst || init_indication)
    begin
      reg_valid_flag <= 1'b0;
      cmd_ready <= 1'b0;
      deadline_forced <= 1'b0;
    end
    else if (counting_reg && !reg_valid_flag)
    begin
      if (self_test_done)
      begin
        reg_valid_flag <= 1'b1;
        cmd_ready <= 1'b1;
      end
      else if (init_cnt_reg >= deadline - 1'b1)
      begin
        reg_valid_flag <= 1'b1;
        cmd_ready <= 1'b1;
        deadline_forced <= 1'b1;
      end
    end
  end

  // ================================================================
  // host interrupt, active low
  always_ff @(posedge clock)
  begin
    if (srst)
      host_irq_n <= 1'b1;
    else
      host_irq_n <= ~(irq_enable & response_avail);
  end

  // ================================================================
  // i2c protocol engine
  i2c_state_e state_reg;
  logic [7:0] rx_shift_reg;
  logic [7:0] tx_shift_reg;
  logic [2:0] bit_cnt_reg;
  logic byte_done_reg;
  logic first_wr_reg;
  logic [7:0] ptr_reg;
  logic [6:0] dev_addr_reg;
  logic [1:0] stretch_cnt_reg;
  logic load_pend_reg;
  logic wr_hold_reg;
  logic mem_wr;
  logic [7:0] tx_byte;
  logic [7:0] mem_rd;
  logic [7:0] mem_ptr;
  logic addr_hit;
  assign mem_ptr = ptr_reg - `REG_MEM_BASE;
  // single 7-bit address; lsb of the byte is direction, 1 reads
  assign addr_hit = (rx_shift_reg[7:1] == dev_addr_reg);
  assign mem_wr = (state_reg == ST_WR_BYTE) && byte_done_reg && scl_fall
    && !first_wr_reg && (ptr_reg >= `REG_MEM_BASE);

  reg_mem #(.DEPTH(MEM_DEPTH), .WIDTH(8), .AW(MEM_AW)) u_mem (
    .clock(clock),
    .wr_en(mem_wr),
    .wr_addr(mem_ptr[MEM_AW-1:0]),
    .wr_data(rx_shift_reg),
    .rd_addr(mem_ptr[MEM_AW-1:0]),
    .rd_data(mem_rd)
  );
  // access byte built from the reg_valid_flag flop and the crb_mode input, never from memory
  always_comb
  begin
    tx_byte = `READ_IDLE;
    case (ptr_reg)
      `REG_ACCESS: tx_byte = {reg_valid_flag, 6'h00, crb_mode};
      `REG_STATUS: tx_byte = {6'h00, response_avail, cmd_ready};
      `REG_CAP: tx_byte = {6'h00, SPEED_CAP};
      `REG_DEV_ADDR: tx_byte = {1'b0, dev_addr_reg};
      default: tx_byte = reg_valid_flag ? mem_rd : `READ_IDLE;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      state_reg <= ST_IDLE;
    else if (start_det)
      state_reg <= ST_ADDR;
    else if (stop_det)
      state_reg <= ST_IDLE;
    else if (scl_fall)
    begin
      case (state_reg)
        ST_ADDR: state_reg <= !byte_done_reg ? ST_ADDR : addr_hit ? ST_ADDR_ACK : ST_IDLE;
        ST_ADDR_ACK: state_reg <= rx_shift_reg[0] ? ST_RD_BYTE : ST_WR_BYTE;
        ST_WR_BYTE: state_reg <= byte_done_reg ? ST_WR_ACK : ST_WR_BYTE;
        ST_WR_ACK: state_reg <= ST_WR_BYTE;
        ST_RD_BYTE: state_reg <= (bit_cnt_reg == 3'h7) ? ST_RD_ACK : ST_RD_BYTE;
        ST_RD_ACK: state_reg <= rx_shift_reg[0] ? ST_IDLE : ST_RD_BYTE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
  // receive shifter; in read ack, bit 0 holds the master nack
  always_ff @(posedge clock)
  begin
    if (srst || start_det)
    begin
      rx_shift_reg <= 8'h00;
      bit_cnt_reg <= 3'h0;
      byte_done_reg <= 1'b0;
    end
    else if (scl_rise)
    begin
      case (state_reg)
        ST_ADDR, ST_WR_BYTE:
        begin
          rx_shift_reg <= {rx_shift_reg[6:0], sda_s};
          bit_cnt_reg <= bit_cnt_reg + 3'h1;
          byte_done_reg <= (bit_cnt_reg == 3'h7);
        end
        ST_RD_ACK: rx_shift_reg <= {7'h00, sda_s};
        default: byte_done_reg <= 1'b0;
      endcase
    end
    else if (scl_fall && byte_done_reg)
    begin
      byte_done_reg <= 1'b0;
      bit_cnt_reg <= 3'h0;
    end
    else if (scl_fall && state_reg == ST_RD_BYTE)
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
  end
  // register pointer: first written byte, auto-increment after
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      ptr_reg <= `REG_ACCESS;
      first_wr_reg <= 1'b0;
    end
    else if (scl_fall && state_reg == ST_ADDR_ACK)
      first_wr_reg <= ~rx_shift_reg[0];
    else if (scl_fall && state_reg == ST_WR_BYTE && byte_done_reg)
    begin
      first_wr_reg <= 1'b0;
      ptr_reg <= first_wr_reg ? rx_shift_reg : ptr_reg + 8'h01;
    end
    else if (scl_fall && state_reg == ST_RD_ACK && !rx_shift_reg[0])
      ptr_reg <= ptr_reg + 8'h01;
  end
  // target address register, writable at its own offset
  always_ff @(posedge clock)
  begin
    if (srst)
      dev_addr_reg <= `DEV_ADDR_RST;
    else if (scl_fall && state_reg == ST_WR_BYTE && byte_done_reg
      && !first_wr_reg && ptr_reg == `REG_DEV_ADDR)
      dev_addr_reg <= rx_shift_reg[6:0];
  end

  // ================================================================
  // clock stretching: read prep waits for registered memory data
  logic rd_load_start;
  assign rd_load_start = scl_fall && ((state_reg == ST_ADDR_ACK && rx_shift_reg[0])
    || (state_reg == ST_RD_ACK && !rx_shift_reg[0]));

  always_ff @(posedge clock)
  begin
    if (srst || start_det || stop_det)
    begin
      load_pend_reg <= 1'b0;
      stretch_cnt_reg <= 2'h0;
    end
    else if (rd_load_start)
    begin
      load_pend_reg <= 1'b1;
      stretch_cnt_reg <= `STRETCH_CYC;
    end
    else if (load_pend_reg && stretch_cnt_reg != 2'h0)
      stretch_cnt_reg <= stretch_cnt_reg - 2'h1;
    else
      load_pend_reg <= 1'b0;
  end

  // write side holds the clock while the core stores data
  always_ff @(posedge clock)
  begin
    if (srst || start_det || stop_det)
      wr_hold_reg <= 1'b0;
    else if (scl_fall && state_reg == ST_WR_ACK)
      wr_hold_reg <= 1'b1;
    else if (!core_busy)
      wr_hold_reg <= 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      scl_oe <= 1'b0;
      scl_out <= 1'b0;
    end
    else
    begin
      scl_out <= 1'b0;
      // only scl is held low to throttle; held through the load so sda leads scl
      scl_oe <= rd_load_start || load_pend_reg
        || (scl_fall && state_reg == ST_WR_ACK) || (wr_hold_reg && core_busy);
    end
  end

  // ================================================================
  // data pin drive: ack and read bits, changed after scl falls
  always_ff @(posedge clock)
  begin
    if (srst)
      tx_shift_reg <= 8'hFF;
    else if (load_pend_reg && stretch_cnt_reg == 2'h0)
      tx_shift_reg <= tx_byte;
    else if (scl_fall && state_reg == ST_RD_BYTE)
      tx_shift_reg <= {tx_shift_reg[6:0], 1'b1};
  end

  always_ff @(posedge clock)
  begin
    if (srst || start_det || stop_det)
    begin
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
    end
    else
    begin
      sda_out <= 1'b0;
      if (load_pend_reg && stretch_cnt_reg == 2'h0)
        sda_oe <= ~tx_byte[7];
      else if (scl_fall)
      begin
        case (state_reg)
          ST_ADDR: sda_oe <= byte_done_reg && addr_hit;
          ST_WR_BYTE: sda_oe <= byte_done_reg;
          ST_RD_BYTE: sda_oe <= (bit_cnt_reg != 3'h7) && ~tx_shift_reg[6];
          default: sda_oe <= 1'b0;
        endcase
      end
    end
  end
endmodule : security_module_i2c_target_init

// ### verilog/sync2.sv
// two-flop synchroniser, one stage pair per bit
`timescale 1ns/1ps
module sync2 #(
  parameter int WIDTH = 2
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      // idle bus level is high, so reset to one
      always_ff @(posedge clock)
      begin
        if (srst)
        begin
          meta_reg[i] <= 1'b1;
          sync_out[i] <= 1'b1;
        end
        else
        begin
          meta_reg[i] <= async_in[i];
          sync_out[i] <= meta_reg[i];
        end
      end
    end
  endgenerate
endmodule : sync2
